// ==== design/t1_link_maintenance_regs.sv ====
// Summary of operation
// - present set after over 126 good windows
// - loop-up present cleared above 600 errors
// - loop-down present cleared above 600 errors
// - loop-up pattern from bit 7 downward
// - loop-down pattern from bit 7 downward
// - loop-up change flag, write-one clears
// - loop-down change flag, write-one clears
// - loop-code interrupt gated by enable bits
// - idle fill replaces data when sync lost in RX slave mode
// - slip flag and slip direction recorded
// - slip interrupt gated by its enable
// - report built and sent once per second
// - report carries five software-written bits
// - transmit code repeated unless all ones
// - message is ones, zero, code, zero
// - select zero: eight of ten, new code
// - select one: four of five, new code
// - length select picks 5/6/7/8 valid bits
// - framing bit skipped or result discarded
// - declared code loaded, bit 5 is MSB
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module t1_link_maintenance_regs #(
  parameter int WINDOW_CYCLES = t1_maint_pkg::LOOP_WINDOW_CYCLES,
  parameter int SECOND_CYCLES = t1_maint_pkg::REPORT_CYCLES
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire t1_maint_pkg::link_in_t link_in,
  output t1_maint_pkg::link_out_t     link_out,
  output logic                        irq
);

  // ==========================================================================
  // helpers
  function automatic logic [3:0] pattern_len(input logic [1:0] sel);
    pattern_len = {2'h0, sel} + 4'h5;
  endfunction : pattern_len

  function automatic logic [3:0] code_hits(input logic [9:0][5:0] hist, input logic [9:0] hv,
                                           input logic [5:0] code, input logic [3:0] span);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 10; i++)
    begin
      if (4'(i) < span && hv[i] && hist[i] == code)
      begin
        c = c + 4'h1;
      end
    end
    code_hits = c;
  endfunction : code_hits

  function automatic logic mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    mapped = a[11:10] == 2'h0 && a[1:0] == 2'h0 &&
             ((i >= t1_maint_pkg::IDX_DET_CFG && i <= t1_maint_pkg::IDX_RX_CODE) || i == t1_maint_pkg::IDX_MODE);
  endfunction : mapped

  // ==========================================================================
  // state
  t1_maint_pkg::state_t s_reg;
  t1_maint_pkg::state_t s_next;
  logic [1:0][9:0]      err_new;
  logic                 win_end;
  logic                 load_bom;
  logic                 load_report;
  logic [7:0]           rd_byte;

  logic                 esf;
  logic                 auto_on;
  logic                 wr_en;
  logic [7:0]           idx;
  logic [7:0]           wd;

  assign esf     = s_reg.mode[t1_maint_pkg::MODE_ESF];
  assign auto_on = s_reg.report_ctl[0] & esf;
  assign idx     = paddr[9:2];
  assign wd      = pwdata[7:0];
  assign wr_en   = psel & penable & pwrite & mapped(paddr);
  assign win_end = s_reg.win_cnt == 21'(WINDOW_CYCLES - 1);

  // ==========================================================================
  // read mux; reserved bits read zero
  always_comb
  begin
    unique case (idx)
      t1_maint_pkg::IDX_DET_CFG:    rd_byte = {3'h0, s_reg.det_cfg};
      t1_maint_pkg::IDX_LC_STATUS:  rd_byte = {6'h0, s_reg.present};
      t1_maint_pkg::IDX_UP_PAT:     rd_byte = s_reg.up_pat;
      t1_maint_pkg::IDX_DN_PAT:     rd_byte = s_reg.dn_pat;
      t1_maint_pkg::IDX_LC_IRQ_EN:  rd_byte = {6'h0, s_reg.lc_en};
      t1_maint_pkg::IDX_LC_FLAGS:   rd_byte = {6'h0, s_reg.lc_flags};
      t1_maint_pkg::IDX_ES_CFG:     rd_byte = {5'h0, s_reg.idle_fill_en, s_reg.slip_dir, s_reg.slip_en};
      t1_maint_pkg::IDX_ES_FLAGS:   rd_byte = {7'h0, s_reg.slip_flag};
      t1_maint_pkg::IDX_IDLE_PAT:   rd_byte = s_reg.idle_pat;
      t1_maint_pkg::IDX_REPORT_CTL: rd_byte = {2'h0, s_reg.report_ctl};
      t1_maint_pkg::IDX_TX_CODE:    rd_byte = {2'h0, s_reg.tx_code};
      t1_maint_pkg::IDX_RX_CTL:     rd_byte = {2'h0, s_reg.message_validation_select, s_reg.boc_en, 4'h0};
      t1_maint_pkg::IDX_RX_FLAGS:   rd_byte = {7'h0, s_reg.boc_flag};
      t1_maint_pkg::IDX_RX_CODE:    rd_byte = {2'h0, s_reg.rx_code};
      t1_maint_pkg::IDX_MODE:       rd_byte = {6'h0, s_reg.mode};
      default:                      rd_byte = 8'h00;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    logic [7:0]  pat;
    logic [3:0]  len;
    logic [6:0]  good_new;
    logic [15:0] sr_new;
    logic [5:0]  code;
    pat         = 8'h00;
    len         = 4'h0;
    good_new    = 7'h00;
    sr_new      = 16'h0000;
    code        = 6'h00;
    load_bom    = 1'b0;
    load_report = 1'b0;
    err_new     = s_reg.err;
    s_next      = s_reg;

    // register writes; flags cleared first so hardware sets below win
    if (wr_en)
    begin
      unique case (idx)
        t1_maint_pkg::IDX_DET_CFG:    s_next.det_cfg = wd[4:0];
        t1_maint_pkg::IDX_UP_PAT:     s_next.up_pat = wd;
        t1_maint_pkg::IDX_DN_PAT:     s_next.dn_pat = wd;
        t1_maint_pkg::IDX_LC_IRQ_EN:  s_next.lc_en = wd[1:0];
        t1_maint_pkg::IDX_LC_FLAGS:   s_next.lc_flags = s_reg.lc_flags & ~wd[1:0];
        t1_maint_pkg::IDX_ES_CFG:
        begin
          s_next.idle_fill_en = wd[t1_maint_pkg::ES_IDLE_EN];
          s_next.slip_en      = wd[0];
        end
        t1_maint_pkg::IDX_ES_FLAGS:   s_next.slip_flag = s_reg.slip_flag & ~wd[0];
        t1_maint_pkg::IDX_IDLE_PAT:   s_next.idle_pat = wd;
        t1_maint_pkg::IDX_REPORT_CTL: s_next.report_ctl = wd[5:0];
        t1_maint_pkg::IDX_TX_CODE:    s_next.tx_code = wd[5:0];
        t1_maint_pkg::IDX_RX_CTL:
        begin
          s_next.message_validation_select    = wd[t1_maint_pkg::RX_AVC];
          s_next.boc_en = wd[t1_maint_pkg::RX_BOC_EN];
        end
        t1_maint_pkg::IDX_RX_FLAGS:   s_next.boc_flag = s_reg.boc_flag & ~wd[0];
        t1_maint_pkg::IDX_MODE:       s_next.mode = wd[1:0];
        default:                      s_next.mode = s_reg.mode;
      endcase
    end

    // read data captured in the setup cycle, answered in the access cycle
    if (psel && !penable)
    begin
      s_next.prdata = mapped(paddr) ? {24'h000000, rd_byte} : 32'h00000000;
    end

    // loop-code detectors: index 1 loop-up, index 0 loop-down
    s_next.win_cnt = win_end ? 21'h000000 : s_reg.win_cnt + 21'h000001;
    for (int d = 0; d < 2; d++)
    begin
      pat = (d == 1) ? s_reg.up_pat : s_reg.dn_pat;
      len = pattern_len((d == 1) ? s_reg.det_cfg[1:0] : s_reg.det_cfg[3:2]);
      if (link_in.bit_valid && !(link_in.is_fbit && s_reg.det_cfg[t1_maint_pkg::DET_SKIP_FBIT]))
      begin
        // first received code bit meets bit 7; a framing bit only advances the phase
        if (!link_in.is_fbit && link_in.bit_val != pat[3'h7 - s_reg.phase[d]] &&
            s_reg.err[d] != t1_maint_pkg::ERR_SAT)
        begin
          err_new[d] = s_reg.err[d] + 10'h001;
        end
        s_next.phase[d] = ({1'b0, s_reg.phase[d]} == len - 4'h1) ? 3'h0 : s_reg.phase[d] + 3'h1;
      end
      s_next.err[d] = err_new[d];
      if (win_end)
      begin
        s_next.err[d] = 10'h000;
        good_new = (s_reg.good[d] == t1_maint_pkg::GOOD_SAT) ? s_reg.good[d] : s_reg.good[d] + 7'h01;
        if (err_new[d] > t1_maint_pkg::LOSS_ERR_LIMIT)
        begin
          s_next.present[d] = 1'b0;
          s_next.good[d]    = 7'h00;
          // hunt: slip the compare phase by one so an unaligned code is found
          s_next.phase[d] = ({1'b0, s_next.phase[d]} >= len - 4'h1) ? 3'h0 : s_next.phase[d] + 3'h1;
        end
        else if (err_new[d] < t1_maint_pkg::LOSS_ERR_LIMIT)
        begin
          s_next.good[d] = good_new;
          if (good_new > t1_maint_pkg::GOOD_WINDOWS)
          begin
            s_next.present[d] = 1'b1;
          end
        end
        else
        begin
          s_next.good[d] = 7'h00;
        end
      end
      if (s_next.present[d] != s_reg.present[d])
      begin
        s_next.lc_flags[d] = 1'b1;
      end
    end

    // elastic store events and idle fill
    if (link_in.slip_event)
    begin
      s_next.slip_flag = 1'b1;
      s_next.slip_dir  = link_in.slip_full;
    end
    s_next.out_valid = link_in.byte_valid;
    if (link_in.byte_valid)
    begin
      s_next.out_byte = (s_reg.mode[t1_maint_pkg::MODE_RX_SLAVE] && link_in.sync_lost && s_reg.idle_fill_en) ?
                        s_reg.idle_pat : link_in.byte_val;
    end

    // data-link transmitter: report has priority over the repeated message
    if (s_reg.sec_cnt == 26'(SECOND_CYCLES - 1))
    begin
      s_next.sec_cnt     = 26'h0000000;
      s_next.report_pend = auto_on;
    end
    else
    begin
      s_next.sec_cnt = s_reg.sec_cnt + 26'h0000001;
    end
    if (!auto_on)
    begin
      s_next.report_pend = 1'b0;
    end
    if (link_in.dl_slot && s_reg.tx_cnt != 5'h00)
    begin
      s_next.tx_sr  = {s_reg.tx_sr[14:0], 1'b1};
      s_next.tx_cnt = s_reg.tx_cnt - 5'h01;
    end
    if (s_reg.tx_cnt == 5'h00)
    begin
      if (s_reg.report_pend && auto_on)
      begin
        load_report        = 1'b1;
        s_next.report_pend = 1'b0;
        s_next.tx_sr       = {t1_maint_pkg::REPORT_FLAG, 3'h0, s_reg.report_ctl[5:1]};
        s_next.tx_cnt      = t1_maint_pkg::MSG_BITS;
      end
      else if (esf && s_reg.tx_code != t1_maint_pkg::TX_CODE_IDLE)
      begin
        load_bom      = 1'b1;
        s_next.tx_sr  = {t1_maint_pkg::MSG_PREAMBLE, 1'b0, s_reg.tx_code[0], s_reg.tx_code[1], s_reg.tx_code[2],
                         s_reg.tx_code[3], s_reg.tx_code[4], s_reg.tx_code[5], 1'b0};
        s_next.tx_cnt = t1_maint_pkg::MSG_BITS;
      end
    end

    // data-link receiver
    if (link_in.dl_valid && esf)
    begin
      sr_new       = {s_reg.rx_sr[14:0], link_in.dl_bit};
      s_next.rx_sr = sr_new;
      if (sr_new[15:8] == t1_maint_pkg::MSG_PREAMBLE && !sr_new[7] && !sr_new[0])
      begin
        code          = {sr_new[1], sr_new[2], sr_new[3], sr_new[4], sr_new[5], sr_new[6]};
        s_next.hist   = {s_reg.hist[8:0], code};
        s_next.hist_v = {s_reg.hist_v[8:0], 1'b1};
        if (code != s_reg.rx_code &&
            (s_reg.message_validation_select ? code_hits(s_next.hist, s_next.hist_v, code, t1_maint_pkg::BOM_SPAN_SHORT)
                         >= t1_maint_pkg::BOM_HITS_SHORT
                       : code_hits(s_next.hist, s_next.hist_v, code, t1_maint_pkg::BOM_SPAN_LONG)
                         >= t1_maint_pkg::BOM_HITS_LONG))
        begin
          s_next.rx_code  = code;
          s_next.boc_flag = 1'b1;
        end
      end
    end

    s_next.irq = |(s_next.lc_flags & s_next.lc_en) | (s_next.slip_flag & s_next.slip_en) |
                 (s_next.boc_flag & s_next.boc_en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg          <= '0;
      s_reg.det_cfg  <= t1_maint_pkg::DET_CFG_RST;
      s_reg.up_pat   <= t1_maint_pkg::UP_PAT_RST;
      s_reg.dn_pat   <= t1_maint_pkg::DN_PAT_RST;
      s_reg.idle_pat <= t1_maint_pkg::IDLE_PAT_RST;
      s_reg.tx_code  <= t1_maint_pkg::TX_CODE_RST;
      s_reg.rx_code  <= t1_maint_pkg::RX_CODE_RST;
      s_reg.mode     <= t1_maint_pkg::MODE_RST;
      s_reg.tx_sr    <= 16'hFFFF;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // outputs; zero wait states, so the answer stands in the access cycle
  assign pready              = 1'b1;
  assign pslverr             = psel & penable & ~mapped(paddr);
  assign prdata              = s_reg.prdata;
  assign irq                 = s_reg.irq;
  assign link_out.byte_valid = s_reg.out_valid;
  assign link_out.byte_val   = s_reg.out_byte;
  assign link_out.dl_bit     = s_reg.tx_sr[15];

  // ==========================================================================
  // checks
  a_up_present_rise: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_reg.present[1]) |-> $past(s_reg.good[1]) == t1_maint_pkg::GOOD_WINDOWS)
    else $error("loop-up present rose too early");

  a_up_loss_clear: assert property (@(posedge pclk) disable iff (!presetn)
    win_end && err_new[1] > t1_maint_pkg::LOSS_ERR_LIMIT |=> !s_reg.present[1] && s_reg.good[1] == 7'h00)
    else $error("loop-up present not cleared on loss");

  a_down_loss_clear: assert property (@(posedge pclk) disable iff (!presetn)
    win_end && err_new[0] > t1_maint_pkg::LOSS_ERR_LIMIT |=> !s_reg.present[0])
    else $error("loop-down present not cleared on loss");

  a_up_change_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(s_reg.present[1]) |-> s_reg.lc_flags[1])
    else $error("loop-up change flag missed");

  a_down_change_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(s_reg.present[0]) |-> s_reg.lc_flags[0])
    else $error("loop-down change flag missed");

  a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> (s_reg.lc_flags[1] && s_reg.lc_en[1]) || (s_reg.lc_flags[0] && s_reg.lc_en[0]) ||
            (s_reg.slip_flag && s_reg.slip_en) || (s_reg.boc_flag && s_reg.boc_en))
    else $error("interrupt without an enabled flag");

  a_idle_fill_data: assert property (@(posedge pclk) disable iff (!presetn)
    link_in.byte_valid && s_reg.mode[t1_maint_pkg::MODE_RX_SLAVE] && link_in.sync_lost && s_reg.idle_fill_en
    |=> link_out.byte_valid && link_out.byte_val == $past(s_reg.idle_pat))
    else $error("idle fill not applied");

  a_slip_capture: assert property (@(posedge pclk) disable iff (!presetn)
    link_in.slip_event |=> s_reg.slip_flag && s_reg.slip_dir == $past(link_in.slip_full))
    else $error("slip event not recorded");

  a_slip_irq: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.slip_flag && s_reg.slip_en |-> irq)
    else $error("slip interrupt missing");

  a_report_off: assert property (@(posedge pclk) disable iff (!presetn)
    !auto_on |-> !load_report ##1 !load_report)
    else $error("report sent while disabled");

  a_idle_code_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.tx_code == t1_maint_pkg::TX_CODE_IDLE |-> !load_bom)
    else $error("message sent for all-ones code");

  a_bom_frame: assert property (@(posedge pclk) disable iff (!presetn)
    load_bom |=> s_reg.tx_sr[15:7] == 9'h1FE && !s_reg.tx_sr[0] && s_reg.tx_sr[6] == $past(s_reg.tx_code[0])
                 && s_reg.tx_cnt == t1_maint_pkg::MSG_BITS)
    else $error("bit message framing wrong");

endmodule : t1_link_maintenance_regs

`default_nettype wire

// ==== design/t1_maint_pkg.sv ====
package t1_maint_pkg;

  // ==========================================================================
  // timing
  localparam int  CLK_PERIOD_NS      = 20;
  localparam real LOOP_WINDOW_MS     = 39.8;
  localparam int  LOOP_WINDOW_CYCLES = $rtoi(LOOP_WINDOW_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam real REPORT_PERIOD_S    = 1.0;
  localparam int  REPORT_CYCLES      = $rtoi(REPORT_PERIOD_S * 1.0e9 / CLK_PERIOD_NS);

  // ==========================================================================
  // thresholds and counts
  localparam logic [9:0] LOSS_ERR_LIMIT = 10'h258;
  localparam logic [9:0] ERR_SAT        = 10'h3FF;
  localparam logic [6:0] GOOD_WINDOWS   = 7'h7E;
  localparam logic [6:0] GOOD_SAT       = 7'h7F;
  localparam logic [3:0] BOM_HITS_LONG  = 4'h8;
  localparam logic [3:0] BOM_SPAN_LONG  = 4'hA;
  localparam logic [3:0] BOM_HITS_SHORT = 4'h4;
  localparam logic [3:0] BOM_SPAN_SHORT = 4'h5;
  localparam logic [4:0] MSG_BITS       = 5'h10;
  localparam logic [7:0] MSG_PREAMBLE   = 8'hFF;
  localparam logic [7:0] REPORT_FLAG    = 8'h7E;
  localparam logic [5:0] TX_CODE_IDLE   = 6'h3F;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_DET_CFG    = 8'h76;
  localparam logic [7:0] IDX_LC_STATUS  = 8'h77;
  localparam logic [7:0] IDX_UP_PAT     = 8'h78;
  localparam logic [7:0] IDX_DN_PAT     = 8'h79;
  localparam logic [7:0] IDX_LC_IRQ_EN  = 8'h7A;
  localparam logic [7:0] IDX_LC_FLAGS   = 8'h7B;
  localparam logic [7:0] IDX_ES_CFG     = 8'h7C;
  localparam logic [7:0] IDX_ES_FLAGS   = 8'h7D;
  localparam logic [7:0] IDX_IDLE_PAT   = 8'h7E;
  localparam logic [7:0] IDX_REPORT_CTL = 8'h7F;
  localparam logic [7:0] IDX_TX_CODE    = 8'h80;
  localparam logic [7:0] IDX_RX_CTL     = 8'h81;
  localparam logic [7:0] IDX_RX_FLAGS   = 8'h82;
  localparam logic [7:0] IDX_RX_CODE    = 8'h83;
  localparam logic [7:0] IDX_MODE       = 8'hF0;

  // ==========================================================================
  // reset values
  localparam logic [4:0] DET_CFG_RST  = 5'h04;
  localparam logic [7:0] UP_PAT_RST   = 8'h08;
  localparam logic [7:0] DN_PAT_RST   = 8'h24;
  localparam logic [7:0] IDLE_PAT_RST = 8'hFF;
  localparam logic [5:0] TX_CODE_RST  = 6'h3F;
  localparam logic [5:0] RX_CODE_RST  = 6'h3F;
  localparam logic [1:0] MODE_RST     = 2'h1;

  // ==========================================================================
  // field positions
  localparam int DET_SKIP_FBIT = 4;
  localparam int ES_IDLE_EN    = 2;
  localparam int RX_AVC        = 5;
  localparam int RX_BOC_EN     = 4;
  localparam int MODE_ESF      = 0;
  localparam int MODE_RX_SLAVE = 1;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       bit_valid;
    logic       bit_val;
    logic       is_fbit;
    logic       byte_valid;
    logic [7:0] byte_val;
    logic       sync_lost;
    logic       dl_valid;
    logic       dl_bit;
    logic       dl_slot;
    logic       slip_event;
    logic       slip_full;
  } link_in_t;

  typedef struct packed {
    logic       byte_valid;
    logic [7:0] byte_val;
    logic       dl_bit;
  } link_out_t;

  typedef struct packed {
    logic [4:0]      det_cfg;
    logic [7:0]      up_pat;
    logic [7:0]      dn_pat;
    logic [1:0]      present;
    logic [1:0]      lc_en;
    logic [1:0]      lc_flags;
    logic            idle_fill_en;
    logic            slip_dir;
    logic            slip_en;
    logic            slip_flag;
    logic [7:0]      idle_pat;
    logic [5:0]      report_ctl;
    logic [5:0]      tx_code;
    logic            message_validation_select;
    logic            boc_en;
    logic            boc_flag;
    logic [5:0]      rx_code;
    logic [1:0]      mode;
    logic [1:0][2:0] phase;
    logic [1:0][9:0] err;
    logic [1:0][6:0] good;
    logic [20:0]     win_cnt;
    logic [25:0]     sec_cnt;
    logic            report_pend;
    logic [15:0]     tx_sr;
    logic [4:0]      tx_cnt;
    logic [15:0]     rx_sr;
    logic [9:0][5:0] hist;
    logic [9:0]      hist_v;
    logic            out_valid;
    logic [7:0]      out_byte;
    logic [31:0]     prdata;
    logic            irq;
  } state_t;

endpackage : t1_maint_pkg

// ==== tb/t1_line_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module t1_line_model (
  input  wire logic                    pclk,
  output var t1_maint_pkg::link_in_t   link_in,
  input  wire t1_maint_pkg::link_out_t link_out
);
  logic [1:0] slot_cnt;
  logic       tx_q[$];
  // ==========================================================================
  // slots every fourth cycle keep the two-cycle spacing the sender needs
  initial
  begin
    link_in  = '0;
    slot_cnt = 2'h0;
  end
  always @(posedge pclk)
  begin
    slot_cnt        <= slot_cnt + 2'h1;
    link_in.dl_slot <= (slot_cnt == 2'h3);
    if (link_in.dl_slot)
      tx_q.push_back(link_out.dl_bit);
  end
  // ==========================================================================
  // line traffic
  task automatic send_msg(input logic [5:0] c, input int n);
    logic [15:0] m;
    m = {8'hFF, 1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0};
    repeat (n)
      for (int i = 15; i >= 0; i--)
      begin
        link_in.dl_valid <= 1'b1;
        link_in.dl_bit   <= m[i];
        @(posedge pclk);
        link_in.dl_valid <= 1'b0;
        link_in.dl_bit   <= ~m[i];
        @(posedge pclk);
      end
  endtask : send_msg
  task automatic slip(input logic full);
    link_in.slip_event <= 1'b1;
    link_in.slip_full  <= full;
    @(posedge pclk);
    link_in.slip_event <= 1'b0;
    link_in.slip_full  <= ~full;
    @(posedge pclk);
  endtask : slip
  task automatic rx_byte(input logic [7:0] v, input logic lost, output logic [8:0] got);
    link_in.byte_valid <= 1'b1;
    link_in.byte_val   <= v;
    link_in.sync_lost  <= lost;
    @(posedge pclk);
    link_in.byte_valid <= 1'b0;
    link_in.byte_val   <= ~v;
    @(posedge pclk);
    got = {link_out.byte_valid, link_out.byte_val};
  endtask : rx_byte
  // one received line bit on every cycle
  task automatic rx_bits(input logic v, input int n);
    link_in.bit_valid <= 1'b1;
    link_in.bit_val   <= v;
    repeat (n) @(posedge pclk);
    link_in.bit_valid <= 1'b0;
  endtask : rx_bits
  task automatic tx_grab(output logic [47:0] v);
    tx_q.delete();
    while (tx_q.size() < 48)
      @(posedge pclk);
    for (int k = 0; k < 48; k++)
      v[47-k] = tx_q[k];
  endtask : tx_grab
endmodule : t1_line_model
`default_nettype wire

// ==== tb/t1_link_maintenance_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module t1_link_maintenance_regs_tb;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic [8:0]              got;
  logic [7:0]              b, pat;
  logic [5:0]              code;
  logic [47:0]             seen;
  int                      n_mismatch, num_checks, cyc;
  t1_maint_pkg::link_in_t  link_in;
  t1_maint_pkg::link_out_t link_out;
  logic [7:0]              r_idx[9] = '{8'h76, 8'h77, 8'h78, 8'h79, 8'h7A, 8'h7E, 8'h80, 8'h83, 8'hF0};
  logic [7:0]              r_val[9] = '{8'h04, 8'h00, 8'h08, 8'h24, 8'h00, 8'hFF, 8'h3F, 8'h3F, 8'h01};
  // short counts keep the run small
  t1_link_maintenance_regs #(.WINDOW_CYCLES(640), .SECOND_CYCLES(120)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_in(link_in), .link_out(link_out), .irq(irq));
  t1_line_model i_line (.pclk(pclk), .link_in(link_in), .link_out(link_out));
  // ==========================================================================
  // helpers
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [15:0] bit_message(input logic [5:0] c);
    bit_message = {8'hFF, 1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0};
  endfunction : bit_message
  function automatic logic has(input logic [47:0] v, input logic [15:0] m);
    has = 1'b0;
    for (int i = 0; i <= 32; i++)
      if (v[i +: 16] === m)
        has = 1'b1;
  endfunction : has
  // ==========================================================================
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'h2d55));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, r_idx[i], '0);
      chk(rd, {24'h0, r_val[i]});
    end
    apb(1'b0, 8'h90, '0);
    chk({31'h0, err}, 32'h1);
    b = 8'($urandom);
    i_line.slip(b[0]);
    apb(1'b0, t1_maint_pkg::IDX_ES_CFG, '0);
    chk(rd, {30'h0, b[0], 1'b0});
    apb(1'b1, t1_maint_pkg::IDX_ES_FLAGS, '0);
    apb(1'b0, t1_maint_pkg::IDX_ES_FLAGS, '0);
    chk(rd, 32'h1);
    apb(1'b1, t1_maint_pkg::IDX_ES_CFG, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, t1_maint_pkg::IDX_ES_FLAGS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    pat = 8'($urandom);
    apb(1'b1, t1_maint_pkg::IDX_MODE, 32'h3);
    apb(1'b1, t1_maint_pkg::IDX_ES_CFG, 32'h4);
    apb(1'b1, t1_maint_pkg::IDX_IDLE_PAT, {24'h0, pat});
    i_line.rx_byte(b, 1'b1, got);
    chk({23'h0, got}, {23'h0, 1'b1, pat});
    i_line.rx_byte(b, 1'b0, got);
    chk({23'h0, got}, {23'h0, 1'b1, b});
    code = 6'($urandom_range(62));
    apb(1'b1, t1_maint_pkg::IDX_TX_CODE, {26'h0, code});
    i_line.tx_grab(seen);
    chk({31'h0, has(seen, bit_message(code))}, 32'h1);
    // let the message in flight finish before looking for idle ones
    apb(1'b1, t1_maint_pkg::IDX_TX_CODE, 32'h3F);
    repeat (80) @(posedge pclk);
    i_line.tx_grab(seen);
    chk({31'h0, &seen}, 32'h1);
    // a report period shorter than the grab guarantees one whole report inside it
    apb(1'b1, t1_maint_pkg::IDX_REPORT_CTL, {26'h0, b[5:1], 1'b1});
    i_line.tx_grab(seen);
    chk({31'h0, has(seen, {t1_maint_pkg::REPORT_FLAG, 3'h0, b[5:1]})}, 32'h1);
    for (int s = 0; s < 2; s++)
    begin
      code = (s == 0) ? 6'($urandom_range(62)) : ({1'b0, code[4:0]} ^ 6'h01);
      apb(1'b1, t1_maint_pkg::IDX_RX_CTL, {26'h0, s[0], 5'h0});
      i_line.send_msg(code, (s == 0) ? 8 : 4);
      apb(1'b0, t1_maint_pkg::IDX_RX_CODE, '0);
      chk(rd, {26'h0, code});
      apb(1'b0, t1_maint_pkg::IDX_RX_FLAGS, '0);
      chk(rd, 32'h1);
      apb(1'b1, t1_maint_pkg::IDX_RX_FLAGS, 32'h1);
    end
    // constant targets agree with every compare phase, so the hunt cannot hide a result
    apb(1'b1, t1_maint_pkg::IDX_UP_PAT, '0);
    apb(1'b1, t1_maint_pkg::IDX_DN_PAT, 32'hFF);
    apb(1'b1, t1_maint_pkg::IDX_LC_IRQ_EN, 32'h2);
    i_line.rx_bits(1'b0, 128 * 640);
    apb(1'b0, t1_maint_pkg::IDX_LC_STATUS, '0);
    chk(rd, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, t1_maint_pkg::IDX_LC_FLAGS, 32'h3);
    i_line.rx_bits(1'b1, 3 * 640);
    apb(1'b0, t1_maint_pkg::IDX_LC_STATUS, '0);
    chk(rd, 32'h0);
    apb(1'b0, t1_maint_pkg::IDX_LC_FLAGS, '0);
    chk(rd, 32'h2);
    test_done();
  end
endmodule : t1_link_maintenance_regs_tb
`default_nettype wire
